// ===== cse_defines.svh
`ifndef CSE_DEFINES_SVH
`define CSE_DEFINES_SVH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define CSE_OFF_ENTRY   12'h000
`define CSE_OFF_KEY     12'h004
`define CSE_OFF_STATUS  12'h008

// ----------------------------------------
// Field positions
// ----------------------------------------
`define CSE_ENT_W       26
`define CSE_KEY_W       5
`define CSE_ST_SRC      0
`define CSE_ST_BLINK    2
`define CSE_ST_AUTO     3
`define CSE_ST_BUSY     4
`define CSE_ST_BAD      5
`define CSE_ST_PEN      6
`define CSE_ST_MSTEP    8
`define CSE_ST_RSTEP    16
`define CSE_ST_MBROW    24

// ----------------------------------------
// Reset values and sizes
// ----------------------------------------
`define CSE_RST_MSTEP   7'h01
`define CSE_RST_RSTEP   7'h00
`define CSE_NSET        100
`define CSE_ROWS        8
`define CSE_UNIT_COLS   72
`define CSE_MAX_UNITS   5

// ----------------------------------------
// Timing
// ----------------------------------------
`define CSE_CLK_HZ      10000000
`define CSE_MSG_MS      500
`define CSE_BLINK_MS    250

`endif

// ===== cse_editor.sv
`include "cse_defines.svh"

// How it works
// R1: Exactly one source lamp lit steadily: memory, relays or edited.
// R2: Memory key shows setup at memory step, or keyed location 1..100.
// R3: Memory scrolling steps memory step by one, skipping location 0.
// R4: Relays key with location loads relays and relay step; 0 keeps relays.
// R5: Relay scrolling onto location 0 leaves relays unchanged.
// R6: Remote setup change refreshes display only under memory source.
// R7: Remote or trigger relay change refreshes display only under relays.
// R8: Columns valid up to 72 per unit, 360 for five units.
// R9: Open and close edit a valid point; auto mode drives relay too.
// R10: Clear blanks display; auto mode opens all relays.
// R11: Every edit lights edited lamp; scrolling ignored while edited.
// R12: Pen toggles point or row select; miss shows pen message briefly.
// R13: Copy to memory stores display at step or keyed location.
// R14: Copy to memory outside 1..100 is refused with bad entry.
// R15: Copy to relays drives display; memory source sets relay step.
// R16: Relay source keeps relay step; edited source returns to relays.
// R17: Auto mode sends every display change except a remote setup change to relays; memory scrolling moves both steps together.
// R18: Edit in auto mode under relays blinks edited lamp, relays stay lit.
// R19: Insert and delete work only under memory source.
// R20: Insert shifts setups up, drops 100, blanks slot, text blanked.
// R21: Delete shifts setups down, clears 100, shows new setup.
// R22: Every setup holds all unit slices; insert and delete move all.
module cse_editor
    import cse_pkg::*;
#(
    parameter int NSET      = `CSE_NSET,
    parameter int ROWS      = `CSE_ROWS,
    parameter int UNIT_COLS = `CSE_UNIT_COLS,
    parameter int UNITS     = 1,
    parameter int MSG_CYC   = `CSE_MSG_MS * (`CSE_CLK_HZ / 1000),
    parameter int BLINK_CYC = `CSE_BLINK_MS * (`CSE_CLK_HZ / 1000)
) (
    input  wire logic                            I_SYS_CLK,
    input  wire logic                            I_RESETN,
    input  wire logic                            I_PSEL,
    input  wire logic                            I_PENABLE,
    input  wire logic                            I_PWRITE,
    input  wire logic [11:0]                     I_PADDR,
    input  wire logic [31:0]                     I_PWDATA,
    output logic      [31:0]                     O_PRDATA,
    output logic                                 O_PREADY,
    output logic                                 O_PSLVERR,
    output logic      [ROWS*UNIT_COLS*UNITS-1:0] O_DISPLAY,
    output logic      [ROWS*UNIT_COLS*UNITS-1:0] O_RELAY,
    output logic      [ROWS-1:0]                 O_MB_ROWS,
    output logic                                 O_LED_MEM,
    output logic                                 O_LED_RLY,
    output logic                                 O_LED_EDIT,
    output logic                                 O_LED_AUTO,
    output logic                                 O_MSG_BAD,
    output logic                                 O_MSG_PEN,
    output logic                                 O_TEXT_BLANK
);

    // ----------------------------------------
    // Sizes
    // ----------------------------------------
    localparam int COLS = UNIT_COLS * UNITS;
    localparam int NPT  = ROWS * COLS;
    localparam int PTW  = $clog2(NPT);

    typedef struct packed {
        logic [NPT-1:0]            disp;
        logic [NPT-1:0]            relay;
        logic [NSET:1][NPT-1:0]    mem;
        cse_src_e                  src;
        logic                      blink;
        logic                      auto_on;
        logic [6:0]                mstep;
        logic [6:0]                rstep;
        cse_entry_s                entry;
        cse_op_e                   op;
        logic [6:0]                idx;
        logic [31:0]               bad_cnt;
        logic [31:0]               pen_cnt;
        logic [31:0]               blk_cnt;
        logic                      blk_ph;
        logic [ROWS-1:0]           mb_rows;
        logic                      pready;
        logic                      pslverr;
        logic [31:0]               prdata;
        logic                      led_mem;
        logic                      led_rly;
        logic                      led_edit;
        logic                      msg_bad;
        logic                      msg_pen;
        logic                      blank;
    } cse_state_s;

    localparam cse_state_s ST_RST = '{
        src:     SRC_RLY,
        mstep:   `CSE_RST_MSTEP,
        rstep:   `CSE_RST_RSTEP,
        op:      OP_IDLE,
        led_rly: 1'b1,
        default: '0
    };

    cse_state_s s;
    cse_state_s next_s;

    // ----------------------------------------
    // Decode helpers
    // ----------------------------------------
    cse_entry_s     e;
    cse_key_e       key;
    cse_key_e       kk;
    logic           acc;
    logic           key_go;
    logic           loc_mem_ok;
    logic           loc_rly_ok;
    logic           pt_ok;
    logic [PTW-1:0] pt;
    logic [6:0]     loc7;
    logic [6:0]     m_up;
    logic [6:0]     m_dn;
    logic [6:0]     r_up;
    logic [6:0]     r_dn;
    logic           edited;

    assign e      = s.entry;
    assign key    = cse_key_e'(I_PWDATA[`CSE_KEY_W-1:0]);
    assign acc    = I_PSEL & I_PENABLE & s.pready;
    // Keys arriving while a shift is running are dropped
    assign key_go = acc & I_PWRITE & (I_PADDR == `CSE_OFF_KEY)
                  & (s.op == OP_IDLE);
    assign loc7   = e.loc[6:0];
    assign loc_mem_ok = (e.loc >= 10'd1) && (e.loc <= 10'(NSET));
    assign loc_rly_ok = (e.loc <= 10'(NSET));
    assign pt_ok  = (int'(e.row) < ROWS) && (e.col >= 9'd1)
                  && (int'(e.col) <= COLS); // R8
    assign pt     = PTW'(int'(e.row) * COLS + int'(e.col) - 1);
    assign m_up   = (s.mstep == 7'(NSET)) ? 7'h01 : s.mstep + 7'h01; // R3
    assign m_dn   = (s.mstep <= 7'h01) ? 7'(NSET) : s.mstep - 7'h01; // R3
    assign r_up   = (s.rstep == 7'(NSET)) ? 7'h00 : s.rstep + 7'h01;
    assign r_dn   = (s.rstep == 7'h00) ? 7'(NSET) : s.rstep - 7'h01;
    assign edited = (s.src == SRC_EDIT) | s.blink;

    // With a location keyed and nothing edited, Enter acts as the key of the lit source
    always_comb begin
        kk = key;
        if (key == KEY_ENTER && e.keyed && !edited) begin
            kk = (s.src == SRC_MEM) ? KEY_MEMORY : KEY_RELAYS;
        end
    end

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    always_comb begin
        logic       edit;
        logic       shown;
        logic       bad;
        logic       miss;
        logic [6:0] tgt;
        logic [31:0] stat;
        edit   = 1'b0;
        shown  = 1'b0;
        bad    = 1'b0;
        miss   = 1'b0;
        tgt    = e.keyed ? loc7 : s.mstep;
        stat   = '0;
        next_s = s;

        // APB: answer in the access phase, zero wait states
        stat[`CSE_ST_SRC+:2]   = s.src;
        stat[`CSE_ST_BLINK]    = s.blink;
        stat[`CSE_ST_AUTO]     = s.auto_on;
        stat[`CSE_ST_BUSY]     = (s.op != OP_IDLE);
        stat[`CSE_ST_BAD]      = s.msg_bad;
        stat[`CSE_ST_PEN]      = s.msg_pen;
        stat[`CSE_ST_MSTEP+:7] = s.mstep;
        stat[`CSE_ST_RSTEP+:7] = s.rstep;
        stat[`CSE_ST_MBROW+:8] = 8'(s.mb_rows);
        next_s.pready  = I_PSEL & ~I_PENABLE;
        next_s.pslverr = 1'b0;
        next_s.prdata  = '0;
        if (I_PSEL & ~I_PENABLE) begin
            unique case (I_PADDR)
                `CSE_OFF_ENTRY:  next_s.prdata = 32'(s.entry);
                `CSE_OFF_KEY:    next_s.prdata = '0;
                `CSE_OFF_STATUS: next_s.prdata = stat;
                default:         next_s.pslverr = 1'b1;
            endcase
        end
        if (acc & I_PWRITE & (I_PADDR == `CSE_OFF_ENTRY)) begin
            next_s.entry = cse_entry_s'(I_PWDATA[`CSE_ENT_W-1:0]);
        end

        if (key_go) begin
            next_s.entry.keyed = 1'b0;
            unique case (kk)
                KEY_MEMORY: begin
                    if (e.keyed && !loc_mem_ok) begin
                        bad = 1'b1; // R2
                    end else begin
                        next_s.mstep = tgt; // R2
                        next_s.disp  = s.mem[tgt];
                        next_s.src   = SRC_MEM;
                        next_s.blink = 1'b0;
                        shown        = 1'b1;
                    end
                end
                KEY_RELAYS: begin
                    if (e.keyed && !loc_rly_ok) begin
                        bad = 1'b1;
                    end else begin
                        if (e.keyed) begin
                            next_s.rstep = loc7; // R4
                            if (loc7 != 7'h00) begin
                                next_s.relay = s.mem[loc7]; // R4
                            end
                        end
                        next_s.disp  = next_s.relay;
                        next_s.src   = SRC_RLY;
                        next_s.blink = 1'b0;
                    end
                end
                KEY_SCROLL_UP, KEY_SCROLL_DN: begin
                    if (!edited && s.src == SRC_MEM) begin // R11
                        next_s.mstep = (kk == KEY_SCROLL_UP) ? m_up : m_dn;
                        next_s.disp  = s.mem[next_s.mstep]; // R3
                        shown        = 1'b1;
                        if (s.auto_on) begin
                            next_s.rstep = next_s.mstep; // R17
                        end
                    end else if (!edited) begin
                        next_s.rstep = (kk == KEY_SCROLL_UP) ? r_up : r_dn;
                        if (next_s.rstep != 7'h00) begin // R5
                            next_s.relay = s.mem[next_s.rstep];
                            next_s.disp  = next_s.relay;
                        end
                    end
                end
                KEY_OPEN, KEY_CLOSE: begin
                    if (pt_ok) begin
                        next_s.disp[pt] = (kk == KEY_CLOSE); // R9
                        edit  = 1'b1;
                        shown = 1'b1;
                    end else begin
                        bad = 1'b1; // R9
                    end
                end
                KEY_CLEAR: begin
                    next_s.disp = '0; // R10
                    edit  = 1'b1;
                    shown = 1'b1;
                end
                KEY_PEN: begin
                    if (e.pen == PEN_POINT && pt_ok) begin
                        next_s.disp[pt] = ~s.disp[pt]; // R12
                        edit  = 1'b1;
                        shown = 1'b1;
                    end else if (e.pen == PEN_ROW && int'(e.row) < ROWS) begin
                        next_s.mb_rows[e.row] = ~s.mb_rows[e.row]; // R12
                    end else begin
                        // Display is untouched, so it reverts by itself
                        miss = 1'b1; // R12
                    end
                end
                KEY_COPY_MEM: begin
                    if (e.keyed && !loc_mem_ok) begin
                        bad = 1'b1; // R14
                    end else begin
                        next_s.mem[tgt] = s.disp; // R13
                        next_s.mstep    = tgt;
                        if (s.src == SRC_EDIT) begin
                            next_s.src = SRC_MEM; // R13
                        end
                    end
                end
                KEY_COPY_RLY: begin
                    next_s.relay = s.disp; // R15
                    next_s.blink = 1'b0;
                    if (s.src == SRC_MEM) begin
                        next_s.rstep = s.mstep; // R15
                    end else if (s.src == SRC_EDIT) begin
                        next_s.src = SRC_RLY; // R16
                    end
                end
                KEY_AUTO: begin
                    next_s.auto_on = ~s.auto_on; // R17
                end
                KEY_INSERT, KEY_DELETE: begin
                    if (s.src == SRC_MEM) begin // R19
                        if (e.keyed && !loc_mem_ok) begin
                            bad = 1'b1;
                        end else begin
                            next_s.mstep = tgt; // R20 R21
                            next_s.op  = (kk == KEY_INSERT) ? OP_INS : OP_DEL;
                            next_s.idx = (kk == KEY_INSERT) ? 7'(NSET) : tgt;
                        end
                    end
                end
                KEY_REM_MEM: begin
                    if (loc_mem_ok && pt_ok) begin
                        next_s.mem[loc7][pt] = e.val;
                        if (s.src == SRC_MEM && loc7 == s.mstep) begin
                            next_s.disp[pt] = e.val; // R6
                        end
                    end else begin
                        bad = 1'b1;
                    end
                end
                KEY_REM_RLY: begin
                    if (pt_ok) begin
                        next_s.relay[pt] = e.val;
                        if (s.src == SRC_RLY && !s.blink) begin
                            next_s.disp[pt] = e.val; // R7
                        end
                    end else begin
                        bad = 1'b1;
                    end
                end
                KEY_TRIGGER: begin
                    if (loc_mem_ok) begin
                        next_s.relay = s.mem[loc7];
                        next_s.rstep = loc7;
                        if (s.src == SRC_RLY && !s.blink) begin
                            next_s.disp = s.mem[loc7]; // R7
                        end
                    end
                end
                default: begin
                end
            endcase
            if (edit) begin
                if (s.auto_on && s.src == SRC_RLY) begin
                    next_s.blink = 1'b1; // R18
                end else begin
                    next_s.src = SRC_EDIT; // R11
                end
            end
            if (s.auto_on && shown) begin
                next_s.relay = next_s.disp; // R17 R9 R10
            end
        end

        // One slot per cycle; the whole setup word, all units at once
        unique case (s.op)
            OP_INS: begin
                if (s.idx > s.mstep) begin
                    next_s.mem[s.idx] = s.mem[s.idx - 7'h01]; // R20 R22
                    next_s.idx = s.idx - 7'h01;
                end else begin
                    next_s.mem[s.mstep] = '0; // R20
                    next_s.disp = '0;
                    next_s.op   = OP_IDLE;
                end
            end
            OP_DEL: begin
                if (s.idx < 7'(NSET)) begin
                    next_s.mem[s.idx] = s.mem[s.idx + 7'h01]; // R21 R22
                    next_s.idx = s.idx + 7'h01;
                end else begin
                    next_s.mem[NSET] = '0; // R21
                    next_s.disp = next_s.mem[s.mstep];
                    next_s.op   = OP_IDLE;
                end
            end
            OP_IDLE: begin
            end
        endcase
        if (s.op != OP_IDLE && next_s.op == OP_IDLE && s.auto_on) begin
            next_s.relay = next_s.disp; // R17
        end

        // Message timers restart on a fresh event
        next_s.bad_cnt = bad ? 32'(MSG_CYC)
                       : (s.bad_cnt != '0) ? s.bad_cnt - 32'd1 : '0;
        next_s.pen_cnt = miss ? 32'(MSG_CYC)
                       : (s.pen_cnt != '0) ? s.pen_cnt - 32'd1 : '0;
        if (s.blk_cnt >= 32'(BLINK_CYC - 1)) begin
            next_s.blk_cnt = '0;
            next_s.blk_ph  = ~s.blk_ph;
        end else begin
            next_s.blk_cnt = s.blk_cnt + 32'd1;
        end

        next_s.led_mem  = (next_s.src == SRC_MEM); // R1
        next_s.led_rly  = (next_s.src == SRC_RLY); // R1
        next_s.led_edit = (next_s.src == SRC_EDIT)
                        | (next_s.blink & next_s.blk_ph); // R18
        next_s.msg_bad  = (next_s.bad_cnt != '0);
        next_s.msg_pen  = (next_s.pen_cnt != '0);
        next_s.blank    = (next_s.op != OP_IDLE); // R20 R21
    end

    always_ff @(posedge I_SYS_CLK or negedge I_RESETN) begin
        if (!I_RESETN) begin
            s <= ST_RST;
        end else begin
            s <= next_s;
        end
    end

    assign O_PRDATA     = s.prdata;
    assign O_PREADY     = s.pready;
    assign O_PSLVERR    = s.pslverr;
    assign O_DISPLAY    = s.disp;
    assign O_RELAY      = s.relay;
    assign O_MB_ROWS    = s.mb_rows;
    assign O_LED_MEM    = s.led_mem;
    assign O_LED_RLY    = s.led_rly;
    assign O_LED_EDIT   = s.led_edit;
    assign O_LED_AUTO   = s.auto_on;
    assign O_MSG_BAD    = s.msg_bad;
    assign O_MSG_PEN    = s.msg_pen;
    assign O_TEXT_BLANK = s.blank;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    default clocking cb @(posedge I_SYS_CLK); endclocking
    default disable iff (!I_RESETN);

    sequence ins_go;
        key_go && kk == KEY_INSERT && s.src == SRC_MEM
        && (!e.keyed || loc_mem_ok);
    endsequence
    sequence ins_done;
        !s.blank && s.disp == '0 && s.op == OP_IDLE;
    endsequence

    AST_ONE_SOURCE: assert property ( // R1
        $onehot({s.led_mem, s.led_rly, s.src == SRC_EDIT}))
        else $error("source lamps not one-hot");
    AST_MSTEP_RANGE: assert property ( // R3
        s.mstep >= 7'h01 && s.mstep <= 7'(NSET))
        else $error("memory step out of range");
    AST_SCROLL_EDITED: assert property ( // R11
        key_go && kk == KEY_SCROLL_UP && edited
        |=> $stable(s.mstep) && $stable(s.rstep) && $stable(s.relay))
        else $error("scroll acted while edited");
    AST_RLY_ZERO: assert property ( // R5
        key_go && kk == KEY_SCROLL_UP && s.src == SRC_RLY && !edited
        && s.rstep == 7'(NSET)
        |=> s.rstep == 7'h00 && $stable(s.relay))
        else $error("relays moved at step zero");
    AST_CLEAR: assert property ( // R10
        key_go && kk == KEY_CLEAR && s.auto_on
        |=> s.disp == '0 && s.relay == '0)
        else $error("clear left points on");
    AST_COPY_MEM_BAD: assert property ( // R14
        key_go && kk == KEY_COPY_MEM && e.keyed && !loc_mem_ok
        |=> $stable(s.mem) && s.msg_bad)
        else $error("bad copy not refused");
    AST_COPY_RLY: assert property ( // R15
        key_go && kk == KEY_COPY_RLY && s.src == SRC_MEM
        |=> s.rstep == $past(s.mstep) && s.relay == $past(s.disp))
        else $error("copy to relays wrong");
    AST_INS_GATED: assert property ( // R19
        key_go && (kk == KEY_INSERT || kk == KEY_DELETE)
        && s.src != SRC_MEM |=> s.op == OP_IDLE)
        else $error("insert outside memory source");
    AST_INSERT: assert property ( // R20
        ins_go |=> s.blank ##[1:110] ins_done)
        else $error("insert did not finish blank");
    AST_AUTO_STEP: assert property ( // R17
        key_go && kk == KEY_SCROLL_DN && s.src == SRC_MEM && !edited
        && s.auto_on |=> s.rstep == s.mstep)
        else $error("steps did not move together");

endmodule : cse_editor

// ===== cse_pkg.sv
`include "cse_defines.svh"

package cse_pkg;

    typedef enum logic [4:0] {
        KEY_MEMORY, KEY_RELAYS, KEY_ENTER, KEY_SCROLL_UP, KEY_SCROLL_DN,
        KEY_OPEN, KEY_CLOSE, KEY_CLEAR, KEY_PEN, KEY_COPY_MEM,
        KEY_COPY_RLY, KEY_AUTO, KEY_INSERT, KEY_DELETE, KEY_REM_MEM,
        KEY_REM_RLY, KEY_TRIGGER
    } cse_key_e;

    typedef enum logic [1:0] {SRC_MEM, SRC_RLY, SRC_EDIT} cse_src_e;

    typedef enum logic [1:0] {OP_IDLE, OP_INS, OP_DEL} cse_op_e;

    typedef enum logic [1:0] {PEN_MISS, PEN_POINT, PEN_ROW} cse_pen_e;

    typedef struct packed {
        cse_pen_e    pen;
        logic        val;
        logic [8:0]  col;
        logic [2:0]  row;
        logic        keyed;
        logic [9:0]  loc;
    } cse_entry_s;

endpackage : cse_pkg

// ===== cse_relay_card.sv
module cse_relay_card #(
    parameter int W = 576
) (
    input  wire logic         i_clk,
    input  wire logic         i_resetn,
    input  wire logic [W-1:0] i_drive,
    output logic      [W-1:0] o_held,
    output int                o_changes
);
    timeunit 1ns;
    timeprecision 1ns;
    // ----------------------------------------
    // Relay cards
    // ----------------------------------------
    // Change count lets the bench see a step that must not touch contacts
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_held    <= '0;
            o_changes <= 0;
        end else begin
            if (i_drive !== o_held) o_changes <= o_changes + 1;
            o_held <= i_drive;
        end
    end
endmodule : cse_relay_card

// ===== tb.sv
`include "cse_defines.svh"
module tb import cse_pkg::*; ;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int W = 576;
    localparam logic [31:0] SM = 32'h007f7f03;
    logic clk, rstn, psel, pen, pwr, prdy, perr, lm, lr, le, la, mb, mp, tbl;
    logic [11:0] pa;
    logic [31:0] pwd, prd;
    logic [W-1:0] disp, rly, held;
    logic [7:0] rows;
    logic [15:0] lf;
    logic [63:0] q[$];
    logic [63:0] n;
    int chg, c0, r, c, err_total, total_checks;
    cse_editor #(.MSG_CYC(8), .BLINK_CYC(4)) cse_editor_inst (
        .I_SYS_CLK(clk), .I_RESETN(rstn), .I_PSEL(psel), .I_PENABLE(pen),
        .I_PWRITE(pwr), .I_PADDR(pa), .I_PWDATA(pwd), .O_PRDATA(prd),
        .O_PREADY(prdy), .O_PSLVERR(perr), .O_DISPLAY(disp), .O_RELAY(rly),
        .O_MB_ROWS(rows), .O_LED_MEM(lm), .O_LED_RLY(lr), .O_LED_EDIT(le),
        .O_LED_AUTO(la), .O_MSG_BAD(mb), .O_MSG_PEN(mp), .O_TEXT_BLANK(tbl));
    cse_relay_card #(.W(W)) cse_relay_card_inst (.i_clk(clk),
        .i_resetn(rstn), .i_drive(rly), .o_held(held), .o_changes(chg));
    // ----------------------------------------
    // Bus and checking
    // ----------------------------------------
    task automatic chk(input string s, input logic [31:0] v, e);
        total_checks++;
        if (v !== e) begin
            err_total++;
            $display("BAD %s exp %h seen %h", s, e, v);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [11:0] a, input int d);
        @(posedge clk);
        psel <= 1'b1;
        pwr <= w;
        pa <= a;
        pwd <= d;
        @(posedge clk);
        pen <= 1'b1;
        @(posedge clk iff prdy);
        psel <= 1'b0;
        pen <= 1'b0;
    endtask : apb
    // Waits past one more edge so the relay card has taken the new drive
    task automatic key(input cse_key_e k, input int ent);
        apb(1'b1, `CSE_OFF_ENTRY, ent);
        apb(1'b1, `CSE_OFF_KEY, 32'(k));
        repeat (2) @(negedge clk);
    endtask : key
    task automatic st(input logic [31:0] m, input int s, ms, rs);
        q.push_back({m, 32'(rs << 16 | ms << 8 | s)});
        apb(1'b0, `CSE_OFF_STATUS, 0);
    endtask : st
    function automatic int e(input int l);
        return 32'h400 | l;
    endfunction : e
    function automatic logic [15:0] lfsr(input logic [15:0] v);
        return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction : lfsr
    always @(posedge clk iff (psel && pen && prdy && !pwr)) begin
        n = q.pop_front();
        chk("status", prd & n[63:32], n[31:0]);
        chk("slverr", 32'(perr), 32'(pa > 12'h008));
    end
    task automatic final_report;
        $display("checks %0d errors %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : final_report
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    initial begin
        repeat (20000) @(posedge clk);
        err_total++;
        final_report();
    end
    initial begin
        {psel, pen, pwr, pa, pwd} = '0;
        rstn = 1'b0;
        lf = 16'd50074;
        repeat (20) @(posedge clk);
        rstn <= 1'b1;
        st(SM, 1, 1, 0);
        q.push_back(64'hffffffff_00000000);
        apb(1'b0, 12'h010, 0);
        key(KEY_MEMORY, e(5));
        st(SM, 0, 5, 0);
        key(KEY_MEMORY, e(101));
        chk("bad", 32'(mb), 1);
        key(KEY_MEMORY, e(1));
        key(KEY_SCROLL_DN, 0);
        st(SM, 0, 100, 0);
        key(KEY_SCROLL_UP, 0);
        st(SM, 0, 1, 0);
        lf = lfsr(lf);
        r = lf[2:0];
        c = lf % 72 + 1;
        key(KEY_CLOSE, c << 14 | r << 11);
        chk("point", 32'(disp[r*72+c-1]), 1);
        key(KEY_SCROLL_UP, 0);
        st(SM, 2, 1, 0);
        key(KEY_OPEN, 73 << 14);
        chk("col", 32'(mb), 1);
        key(KEY_CLOSE, 72 << 14 | 7 << 11);
        chk("col", 32'(disp[W-1]), 1);
        key(KEY_COPY_MEM, e(0));
        chk("bad", 32'(mb), 1);
        key(KEY_COPY_MEM, e(7));
        st(SM, 0, 7, 0);
        key(KEY_COPY_RLY, 0);
        chk("relay", 32'(rly[W-1]), 1);
        st(SM, 0, 7, 7);
        c0 = chg;
        key(KEY_RELAYS, e(0));
        chk("hold", chg, c0);
        key(KEY_RELAYS, e(100));
        c0 = chg;
        key(KEY_SCROLL_UP, 0);
        chk("hold", chg, c0);
        st(SM, 1, 7, 0);
        key(KEY_INSERT, e(2));
        st(SM | 32'h10, 1, 7, 0);
        key(KEY_AUTO, 0);
        key(KEY_RELAYS, e(7));
        chk("auto", 32'(rly[W-1] & la), 1);
        key(KEY_CLEAR, 0);
        chk("clear", 32'(|{rly, disp}), 0);
        st(SM | 32'h4, 5, 7, 7);
        key(KEY_AUTO, 0);
        key(KEY_MEMORY, e(7));
        key(KEY_INSERT, e(3));
        chk("blank", 32'(tbl), 1);
        repeat (110) @(posedge clk);
        st(SM, 0, 3, 7);
        key(KEY_DELETE, e(3));
        repeat (110) @(posedge clk);
        key(KEY_MEMORY, e(7));
        chk("shift", 32'(disp[W-1]), 1);
        key(KEY_REM_MEM, 1 << 23 | 1 << 14 | e(7));
        chk("remote", 32'(disp[0]), 1);
        key(KEY_TRIGGER, e(7));
        chk("trigger", 32'(rly[0]), 1);
        key(KEY_REM_RLY, 1 << 14);
        chk("remote", 32'(disp[0] & ~rly[0]), 1);
        key(KEY_ENTER, e(5));
        key(KEY_AUTO, 0);
        key(KEY_SCROLL_DN, 0);
        st(SM, 0, 4, 4);
        key(KEY_PEN, 0);
        chk("penmiss", 32'(mp), 1);
        key(KEY_PEN, 2 << 24 | 3 << 11);
        chk("row", 32'(rows[3]), 1);
        c0 = disp[0];
        key(KEY_PEN, 1 << 24 | 1 << 14);
        chk("pen", 32'(disp[0]), 32'(!c0));
        chk("lamps", 32'({lm, lr, le}), 1);
        final_report();
    end
endmodule : tb
